// File: verilog/dipc_pkg.sv
`default_nettype none
package dipc_pkg;
    localparam int ADDR_W = 4;
    localparam int DATA_W = 8;
    localparam int RATIO_W = 3;
    localparam int CNT_W = 8;

    // Register map
    localparam logic [ADDR_W-1:0] ADDR_REG_SLEEP = 4'h0;
    localparam logic [ADDR_W-1:0] ADDR_DOZE_IDLE = 4'h1;

    // Doze and idle control fields
    localparam int IDLE_SEL_BIT = 7;
    localparam int DOZE_EN_BIT = 6;
    localparam int ROI_BIT = 5;
    localparam int DOE_BIT = 4;
    localparam int RATIO_LSB = 0;

    // Regulator control fields
    localparam int REG_PM_BIT = 1;
    localparam int REG_ONE_BIT = 0;

    localparam logic [DATA_W-1:0] DATA_ZERO = 8'h00;
    localparam logic [RATIO_W-1:0] RATIO_RST = 3'h0;
    localparam logic [CNT_W-1:0] CNT_ZERO = 8'h00;
    localparam logic [CNT_W-1:0] CNT_ONE = 8'h01;
    localparam logic [CNT_W-1:0] CNT_FULL = 8'hFF;
    localparam logic [RATIO_W-1:0] RATIO_TOP = 3'h7;

    // Gray along run->idle and run->sleep; 2'b11 is illegal
    typedef enum logic [1:0] {
        DIPC_RUN = 2'h0,
        DIPC_IDLE = 2'h1,
        DIPC_SLEEP = 2'h2
    } dipc_state_t;

    typedef struct packed {
        logic idle_select;
        logic doze_enable;
        logic recover_on_interrupt;
        logic doze_on_exit;
        logic [RATIO_W-1:0] ratio;
    } dipc_doze_ctrl_t;

    // Wrap mask of the peripheral cycle counter: code n gives 1 in 2^(n+1)
    function automatic logic [CNT_W-1:0] dipc_ratio_mask(input logic [RATIO_W-1:0] ratio);
        dipc_ratio_mask = CNT_FULL >> (RATIO_TOP - ratio);
    endfunction : dipc_ratio_mask
endpackage : dipc_pkg
`default_nettype wire

// File: verilog/dipc_doze_div.sv
`timescale 1ns/1ps
`default_nettype none
module dipc_doze_div (
    input wire logic mclk_in,
    input wire logic sys_rst_in,
    input wire logic ce_in,
    input wire logic enable_in,
    input wire logic [dipc_pkg::RATIO_W-1:0] ratio_in,
    input wire logic periph_cycle_in,
    output logic cpu_cycle_out
);
    logic [dipc_pkg::CNT_W-1:0] count_r;
    logic [dipc_pkg::CNT_W-1:0] count_nxt;
    logic cpu_cycle_r;
    logic cpu_cycle_nxt;
    wire logic [dipc_pkg::CNT_W-1:0] mask = dipc_pkg::dipc_ratio_mask(ratio_in);
    wire logic at_start = (count_r == dipc_pkg::CNT_ZERO);

    assign count_nxt = !enable_in ? dipc_pkg::CNT_ZERO :
        !periph_cycle_in ? count_r :
        ((count_r & mask) == mask) ? dipc_pkg::CNT_ZERO : count_r + dipc_pkg::CNT_ONE;
    assign cpu_cycle_nxt = periph_cycle_in && (!enable_in || at_start);
    assign cpu_cycle_out = cpu_cycle_r;

    always_ff @(posedge mclk_in) begin
        if (sys_rst_in) begin
            count_r <= dipc_pkg::CNT_ZERO;
            cpu_cycle_r <= 1'b0;
        end else if (ce_in) begin
            count_r <= count_nxt;
            cpu_cycle_r <= cpu_cycle_nxt;
        end
    end

    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (sys_rst_in);

    a_doze_gap_quiet: assert property (
        ce_in && enable_in && periph_cycle_in && !at_start |=> !cpu_cycle_r)
        else $error("cpu cycle granted inside doze gap");
    a_doze_wrap_point: assert property (
        ce_in && enable_in && periph_cycle_in && ((count_r & mask) == mask) |=> at_start)
        else $error("doze counter did not wrap at ratio");
    a_full_speed_pass: assert property (
        ce_in && !enable_in && periph_cycle_in |=> cpu_cycle_r)
        else $error("cpu cycle dropped with doze off");
endmodule : dipc_doze_div
`default_nettype wire

// File: verilog/dipc_power_control.sv
// Design decisions made here: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module dipc_power_control (
    input wire logic mclk_in,
    input wire logic sys_rst_in,
    input wire logic por_bor_rst_in,
    input wire logic ce_in,
    input wire logic [dipc_pkg::ADDR_W-1:0] addr_in,
    input wire logic [dipc_pkg::DATA_W-1:0] wr_data_in,
    input wire logic wr_en_in,
    input wire logic rd_en_in,
    output logic [dipc_pkg::DATA_W-1:0] rd_data_out,
    input wire logic sleep_exec_in,
    input wire logic isr_entry_in,
    input wire logic return_from_interrupt_in,
    input wire logic irq_pending_in,
    input wire logic wdt_timeout_in,
    input wire logic in_circuit_debug_in,
    input wire logic periph_cycle_in,
    output logic cpu_cycle_en_out,
    output logic cpu_clk_en_out,
    output logic periph_clk_en_out,
    output logic regulator_low_power_out,
    output logic wdt_rst_block_out,
    output logic [1:0] power_state_out,
    output logic wake_out
);
    dipc_pkg::dipc_state_t state_r;
    dipc_pkg::dipc_state_t state_nxt;
    dipc_pkg::dipc_doze_ctrl_t ctrl_r;
    dipc_pkg::dipc_doze_ctrl_t ctrl_nxt;
    logic regulator_power_mode_r;
    logic regulator_power_mode_nxt;
    logic [dipc_pkg::DATA_W-1:0] rd_data_r;
    logic [dipc_pkg::DATA_W-1:0] rd_data_nxt;
    logic wake_r;
    logic wake_nxt;
    logic div_cycle;

    // Bus decode
    wire logic sel_reg = (addr_in == dipc_pkg::ADDR_REG_SLEEP);
    wire logic sel_doze = (addr_in == dipc_pkg::ADDR_DOZE_IDLE);
    wire logic wr_reg = wr_en_in && sel_reg;
    wire logic wr_doze = wr_en_in && sel_doze;

    wire logic in_run = (state_r == dipc_pkg::DIPC_RUN);
    wire logic in_idle = (state_r == dipc_pkg::DIPC_IDLE);
    wire logic in_sleep = (state_r == dipc_pkg::DIPC_SLEEP);

    wire logic roi_clear = isr_entry_in && ctrl_r.recover_on_interrupt;
    wire logic doe_set = return_from_interrupt_in && ctrl_r.doze_on_exit;

    // Hardware changes win over a software write in the same cycle
    assign ctrl_nxt.doze_enable = roi_clear ? 1'b0 :
        doe_set ? 1'b1 :
        wr_doze ? wr_data_in[dipc_pkg::DOZE_EN_BIT] : ctrl_r.doze_enable;
    // idle select only written by software
    assign ctrl_nxt.idle_select = wr_doze ? wr_data_in[dipc_pkg::IDLE_SEL_BIT] : ctrl_r.idle_select;
    assign ctrl_nxt.recover_on_interrupt = wr_doze ? wr_data_in[dipc_pkg::ROI_BIT] :
        ctrl_r.recover_on_interrupt;
    assign ctrl_nxt.doze_on_exit = wr_doze ? wr_data_in[dipc_pkg::DOE_BIT] : ctrl_r.doze_on_exit;
    assign ctrl_nxt.ratio = wr_doze ?
        wr_data_in[dipc_pkg::RATIO_LSB +: dipc_pkg::RATIO_W] : ctrl_r.ratio;
    assign regulator_power_mode_nxt = wr_reg ? wr_data_in[dipc_pkg::REG_PM_BIT] :
        regulator_power_mode_r;

    // Read mux; unmapped addresses read zero
    wire logic [dipc_pkg::DATA_W-1:0] reg_view = dipc_pkg::DATA_ZERO |
        (regulator_power_mode_r << dipc_pkg::REG_PM_BIT) | (1'b1 << dipc_pkg::REG_ONE_BIT);
    wire logic [dipc_pkg::DATA_W-1:0] doze_view = {ctrl_r.idle_select, ctrl_r.doze_enable,
        ctrl_r.recover_on_interrupt, ctrl_r.doze_on_exit, 1'b0, ctrl_r.ratio};
    assign rd_data_nxt = !rd_en_in ? dipc_pkg::DATA_ZERO :
        sel_reg ? reg_view :
        sel_doze ? doze_view : dipc_pkg::DATA_ZERO;

    wire logic wake_req = irq_pending_in || wdt_timeout_in;

    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            dipc_pkg::DIPC_RUN: begin
                if (sleep_exec_in && !irq_pending_in) begin
                    state_nxt = ctrl_r.idle_select ? dipc_pkg::DIPC_IDLE : dipc_pkg::DIPC_SLEEP;
                end
            end
            dipc_pkg::DIPC_IDLE, dipc_pkg::DIPC_SLEEP: begin
                if (wake_req) begin
                    state_nxt = dipc_pkg::DIPC_RUN;
                end
            end
            default: begin
                state_nxt = dipc_pkg::DIPC_RUN;
            end
        endcase
    end
    assign wake_nxt = !in_run && wake_req;

    // reset values
    // One process for the whole struct; idle select ignores writes during system reset
    always_ff @(posedge mclk_in) begin
        if (por_bor_rst_in) begin
            ctrl_r.idle_select <= 1'b0;
        end else if (ce_in && !sys_rst_in) begin
            ctrl_r.idle_select <= ctrl_nxt.idle_select;
        end
        if (sys_rst_in || por_bor_rst_in) begin
            ctrl_r.doze_enable <= 1'b0;
            ctrl_r.recover_on_interrupt <= 1'b0;
            ctrl_r.doze_on_exit <= 1'b0;
            ctrl_r.ratio <= dipc_pkg::RATIO_RST;
            regulator_power_mode_r <= 1'b0;
            state_r <= dipc_pkg::DIPC_RUN;
            rd_data_r <= dipc_pkg::DATA_ZERO;
            wake_r <= 1'b0;
        end else if (ce_in) begin
            ctrl_r.doze_enable <= ctrl_nxt.doze_enable;
            ctrl_r.recover_on_interrupt <= ctrl_nxt.recover_on_interrupt;
            ctrl_r.doze_on_exit <= ctrl_nxt.doze_on_exit;
            ctrl_r.ratio <= ctrl_nxt.ratio;
            regulator_power_mode_r <= regulator_power_mode_nxt;
            state_r <= state_nxt;
            rd_data_r <= rd_data_nxt;
            wake_r <= wake_nxt;
        end
    end

    wire logic doze_active = ctrl_r.doze_enable && !in_circuit_debug_in;

    dipc_doze_div u_doze_div (
        .mclk_in(mclk_in),
        .sys_rst_in(sys_rst_in || por_bor_rst_in),
        .ce_in(ce_in),
        .enable_in(doze_active),
        .ratio_in(ctrl_r.ratio),
        .periph_cycle_in(periph_cycle_in),
        .cpu_cycle_out(div_cycle)
    );

    assign cpu_cycle_en_out = div_cycle && in_run;
    assign cpu_clk_en_out = in_run;
    assign periph_clk_en_out = !in_sleep;
    assign regulator_low_power_out = in_sleep && regulator_power_mode_r;
    assign wdt_rst_block_out = !in_run;
    assign power_state_out = state_r;
    assign wake_out = wake_r;
    assign rd_data_out = rd_data_r;

    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (sys_rst_in || por_bor_rst_in);

    sequence s_sleep_cmd;
        ce_in && in_run && sleep_exec_in && !irq_pending_in;
    endsequence
    sequence s_idle_wake;
        ce_in && in_idle && irq_pending_in && !wr_doze;
    endsequence
    sequence s_wdt_event;
        ce_in && !in_run && wdt_timeout_in;
    endsequence
    sequence s_busy_sleep;
        ce_in && in_run && sleep_exec_in && irq_pending_in;
    endsequence

    // sleep with interrupt pending is a no-op
    a_busy_sleep_nop: assert property (
        s_busy_sleep |=> in_run)
        else $error("sleep with pending interrupt left run");

    a_idle_cpu_halt: assert property (
        in_idle |-> !cpu_cycle_en_out && !cpu_clk_en_out && periph_clk_en_out)
        else $error("idle did not halt only the cpu");

    a_sleep_clocks_off: assert property (
        in_sleep |-> !cpu_clk_en_out && !periph_clk_en_out)
        else $error("sleep left a clock running");

    a_state_legal: assert property (
        in_run || in_idle || in_sleep)
        else $error("power state left legal codes");

    a_cpu_only_run: assert property (
        cpu_cycle_en_out |-> in_run)
        else $error("cpu cycle outside run");

    a_doe_off_keeps: assert property (
        ce_in && return_from_interrupt_in && !ctrl_r.doze_on_exit && !roi_clear && !wr_doze
        |=> $stable(ctrl_r.doze_enable))
        else $error("return changed doze enable");

    a_ratio_write: assert property (
        ce_in && wr_doze |=> ctrl_r.ratio == $past(wr_data_in[dipc_pkg::RATIO_W-1:0]))
        else $error("ratio write not stored");

    a_debug_keeps_doze: assert property (
        ce_in && in_circuit_debug_in && !roi_clear && !doe_set && !wr_doze
        |=> $stable(ctrl_r.doze_enable))
        else $error("debug altered doze enable");

    a_lp_only_sleep: assert property (
        regulator_low_power_out |-> in_sleep && regulator_power_mode_r)
        else $error("low-power regulator outside sleep");

    a_pm_write: assert property (
        ce_in && wr_reg |=> regulator_power_mode_r == $past(wr_data_in[dipc_pkg::REG_PM_BIT]))
        else $error("regulator mode write not stored");

    a_reg_upper_zero: assert property (
        ce_in && rd_en_in && sel_reg
        |=> rd_data_out[dipc_pkg::DATA_W-1:dipc_pkg::REG_PM_BIT+1] == '0)
        else $error("regulator upper bits not zero");

    a_rd_idle_zero: assert property (
        ce_in && !rd_en_in |=> rd_data_out == dipc_pkg::DATA_ZERO)
        else $error("read data stood without a read");

    a_idle_sel_write: assert property (
        ce_in && wr_doze |=> ctrl_r.idle_select == $past(wr_data_in[dipc_pkg::IDLE_SEL_BIT]))
        else $error("idle select write not stored");

    a_idle_sel_hw_kept: assert property (
        ce_in && !wr_doze |=> $stable(ctrl_r.idle_select))
        else $error("idle select changed by hardware");

    a_wake_single: assert property (
        ce_in && wake_out |=> !wake_out)
        else $error("wake pulse longer than one cycle");

    a_run_no_wake: assert property (
        ce_in && in_run |=> !wake_out)
        else $error("wake pulse without leaving low power");

    a_wdt_wakes: assert property (
        s_wdt_event |=> in_run && wake_out)
        else $error("watchdog timeout did not wake");

    a_block_low_power: assert property (
        !in_run |-> wdt_rst_block_out)
        else $error("watchdog reset not blocked in low power");

    a_run_no_block: assert property (
        in_run |-> !wdt_rst_block_out)
        else $error("watchdog reset blocked in run");

    a_ce_freeze: assert property (
        !ce_in |=> $stable(state_r) && $stable(ctrl_r) && $stable(regulator_power_mode_r))
        else $error("state moved with clock enable low");


    a_idle_entry_sel: assert property (
        s_sleep_cmd and ctrl_r.idle_select |=> in_idle && periph_clk_en_out && !cpu_clk_en_out)
        else $error("sleep with idle select did not enter idle");
    a_full_sleep_entry: assert property (
        s_sleep_cmd and !ctrl_r.idle_select |=> in_sleep && !periph_clk_en_out)
        else $error("sleep without idle select did not enter sleep");
    a_nodoze_full_speed: assert property (
        ce_in && in_run && periph_cycle_in && !doze_active && !sleep_exec_in
        |=> cpu_cycle_en_out)
        else $error("full speed cycle missing");
    a_roi_clears_doze: assert property (
        ce_in && roi_clear |=> !ctrl_r.doze_enable)
        else $error("interrupt entry did not clear doze enable");
    a_roi_off_keeps: assert property (
        ce_in && isr_entry_in && !ctrl_r.recover_on_interrupt && !doe_set && !wr_doze
        |=> $stable(ctrl_r.doze_enable))
        else $error("interrupt entry changed doze enable");
    a_doe_sets_doze: assert property (
        ce_in && doe_set && !roi_clear |=> ctrl_r.doze_enable)
        else $error("return did not set doze enable");
    a_debug_full_speed: assert property (
        in_circuit_debug_in && ce_in && periph_cycle_in && in_run && !sleep_exec_in
        |=> div_cycle)
        else $error("debug did not force full speed");
    a_lp_regulator_sleep: assert property (
        s_sleep_cmd and !ctrl_r.idle_select and regulator_power_mode_r and !wr_reg
        |=> regulator_low_power_out)
        else $error("low-power regulator not selected in sleep");
    a_reg_bit_one: assert property (
        ce_in && rd_en_in && sel_reg |=> rd_data_out[dipc_pkg::REG_ONE_BIT])
        else $error("regulator bit 0 did not read as one");
    a_idle_irq_wake: assert property (
        s_idle_wake |=> in_run && wake_out && $stable(ctrl_r.idle_select))
        else $error("idle not ended by interrupt");
    a_wdt_idle_wake: assert property (
        ce_in && in_idle && wdt_timeout_in && !irq_pending_in && !wr_doze && !isr_entry_in
        && !return_from_interrupt_in |-> wdt_rst_block_out ##1 in_run && $stable(ctrl_r.doze_enable))
        else $error("watchdog in idle did not wake cleanly");
    a_idle_keeps_reset: assert property (
        @(posedge mclk_in) disable iff (por_bor_rst_in)
        sys_rst_in |=> $stable(ctrl_r.idle_select) && !ctrl_r.doze_enable)
        else $error("system reset disturbed idle select");
endmodule : dipc_power_control
`default_nettype wire

// File: testbench/dipc_power_control_tb.sv
`timescale 1ns/1ps
`default_nettype none
module dipc_power_control_tb;
    logic mclk_in = 1'b0;
    logic sys_rst_in = 1'b1;
    logic por_bor_rst_in = 1'b1;
    logic ce_in = 1'b1;
    logic [dipc_pkg::ADDR_W-1:0] addr_in = 4'h0;
    logic [dipc_pkg::DATA_W-1:0] wr_data_in = 8'h00;
    logic wr_en_in = 1'b0;
    logic rd_en_in = 1'b0;
    logic sleep_exec_in = 1'b0, isr_entry_in = 1'b0, return_from_interrupt_in = 1'b0;
    logic irq_pending_in = 1'b0, wdt_timeout_in = 1'b0;
    logic in_circuit_debug_in = 1'b0, periph_cycle_in = 1'b0;
    logic [dipc_pkg::DATA_W-1:0] rd_data_out;
    logic cpu_cycle_en_out, cpu_clk_en_out, periph_clk_en_out;
    logic regulator_low_power_out, wdt_rst_block_out, wake_out;
    logic [1:0] power_state_out;
    int bad_count = 0;
    int checks = 0;
    int cyc = 0;
    int cpu_cnt = 0;
    int seed_val;
    logic [3:0] ra;
    logic [7:0] rdat;

    dipc_power_control dipc_power_control_i (
        .mclk_in(mclk_in), .sys_rst_in(sys_rst_in), .por_bor_rst_in(por_bor_rst_in),
        .ce_in(ce_in), .addr_in(addr_in), .wr_data_in(wr_data_in), .wr_en_in(wr_en_in),
        .rd_en_in(rd_en_in), .rd_data_out(rd_data_out), .sleep_exec_in(sleep_exec_in),
        .isr_entry_in(isr_entry_in), .return_from_interrupt_in(return_from_interrupt_in),
        .irq_pending_in(irq_pending_in), .wdt_timeout_in(wdt_timeout_in),
        .in_circuit_debug_in(in_circuit_debug_in), .periph_cycle_in(periph_cycle_in),
        .cpu_cycle_en_out(cpu_cycle_en_out), .cpu_clk_en_out(cpu_clk_en_out),
        .periph_clk_en_out(periph_clk_en_out), .regulator_low_power_out(regulator_low_power_out),
        .wdt_rst_block_out(wdt_rst_block_out), .power_state_out(power_state_out),
        .wake_out(wake_out)
    );

    always #25 mclk_in = ~mclk_in;

    // Whole run needs about 1250 cycles
    always @(posedge mclk_in) begin
        cyc <= cyc + 1;
        if (cpu_cycle_en_out === 1'b1) cpu_cnt <= cpu_cnt + 1;
        if (cyc == 5000) begin
            bad_count++;
            stop_test();
        end
    end

    task automatic stop_test();
        if (bad_count == 0 && checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : stop_test

    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    function automatic logic [7:0] exp_rd(input logic [3:0] a, input logic [7:0] d);
        if (a == dipc_pkg::ADDR_REG_SLEEP) return {6'h00, d[dipc_pkg::REG_PM_BIT], 1'b1};
        if (a == dipc_pkg::ADDR_DOZE_IDLE) return d & 8'hF7;
        return 8'h00;
    endfunction : exp_rd

    function automatic logic [7:0] pw(input logic [1:0] st, input logic wk, input logic lp);
        return {1'b0, st, st == 2'h0, st != 2'h2, st != 2'h0, wk, lp};
    endfunction : pw

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge mclk_in);
        addr_in <= a;
        wr_data_in <= d;
        wr_en_in <= 1'b1;
        @(posedge mclk_in);
        wr_en_in <= 1'b0;
    endtask : wr

    task automatic rd(input logic [3:0] a, input logic [7:0] exp);
        @(posedge mclk_in);
        addr_in <= a;
        rd_en_in <= 1'b1;
        @(posedge mclk_in);
        rd_en_in <= 1'b0;
        #1;
        check("rd_data", rd_data_out, exp);
    endtask : rd

    // Bits: sleep, isr entry, return, watchdog, irq pending
    task automatic ev(input logic [4:0] v);
        @(posedge mclk_in);
        {sleep_exec_in, isr_entry_in, return_from_interrupt_in, wdt_timeout_in, irq_pending_in} <= v;
        @(posedge mclk_in);
        {sleep_exec_in, isr_entry_in, return_from_interrupt_in, wdt_timeout_in, irq_pending_in} <= 5'h00;
        #1;
    endtask : ev

    task automatic pchk(input logic [1:0] st, input logic wk, input logic lp);
        check("power", {1'b0, power_state_out, cpu_clk_en_out, periph_clk_en_out,
            wdt_rst_block_out, wake_out, regulator_low_power_out}, pw(st, wk, lp));
    endtask : pchk

    // Extra edges let the last delayed pulse reach the counter
    task automatic periph_run(input int n, input logic [7:0] exp);
        int c0;
        c0 = cpu_cnt;
        for (int i = 0; i < n + 3; i++) begin
            @(posedge mclk_in);
            periph_cycle_in <= (i < n);
        end
        check("cpu_cycles", 8'(cpu_cnt - c0), exp);
    endtask : periph_run

    initial begin
        seed_val = $urandom(92438);
        repeat (4) @(posedge mclk_in);
        sys_rst_in <= 1'b0;
        por_bor_rst_in <= 1'b0;
        rd(dipc_pkg::ADDR_REG_SLEEP, 8'h01);
        rd(dipc_pkg::ADDR_DOZE_IDLE, 8'h00);
        pchk(2'h0, 1'b0, 1'b0);
        for (int i = 0; i < 10; i++) begin
            ra = 4'($urandom);
            rdat = 8'($urandom);
            wr(ra, rdat);
            rd(ra, exp_rd(ra, rdat));
        end
        wr(4'h1, 8'h15);
        @(posedge mclk_in);
        ce_in <= 1'b0;
        wr(4'h1, 8'hAA);
        @(posedge mclk_in);
        ce_in <= 1'b1;
        rd(4'h1, 8'h15);
        for (int r = 0; r < 8; r++) begin
            wr(4'h1, 8'h00);
            wr(4'h1, 8'h40 | 8'(r));
            periph_run(4 << r, 8'h02);
        end
        wr(4'h1, 8'h00);
        periph_run(10, 8'h0A);
        wr(4'h1, 8'h47);
        @(posedge mclk_in);
        in_circuit_debug_in <= 1'b1;
        periph_run(10, 8'h0A);
        @(posedge mclk_in);
        in_circuit_debug_in <= 1'b0;
        rd(4'h1, 8'h47);
        wr(4'h1, 8'h60);
        ev(5'b01000);
        rd(4'h1, 8'h20);
        wr(4'h1, 8'h40);
        ev(5'b01000);
        rd(4'h1, 8'h40);
        wr(4'h1, 8'h10);
        ev(5'b00100);
        rd(4'h1, 8'h50);
        wr(4'h1, 8'h00);
        ev(5'b00100);
        rd(4'h1, 8'h00);
        wr(4'h0, 8'h03);
        wr(4'h1, 8'hE0);
        ev(5'b10001);
        pchk(2'h0, 1'b0, 1'b0);
        ev(5'b10000);
        pchk(2'h1, 1'b0, 1'b0);
        ev(5'b00010);
        pchk(2'h0, 1'b1, 1'b0);
        rd(4'h1, 8'hE0);
        ev(5'b10000);
        ev(5'b00001);
        pchk(2'h0, 1'b1, 1'b0);
        rd(4'h1, 8'hE0);
        wr(4'h1, 8'h00);
        ev(5'b10000);
        pchk(2'h2, 1'b0, 1'b1);
        ev(5'b00010);
        pchk(2'h0, 1'b1, 1'b0);
        @(posedge mclk_in);
        #1;
        pchk(2'h0, 1'b0, 1'b0);
        wr(4'h0, 8'h01);
        ev(5'b10000);
        pchk(2'h2, 1'b0, 1'b0);
        ev(5'b00001);
        pchk(2'h0, 1'b1, 1'b0);
        wr(4'h1, 8'hFF);
        wr(4'h0, 8'h03);
        @(posedge mclk_in);
        sys_rst_in <= 1'b1;
        @(posedge mclk_in);
        sys_rst_in <= 1'b0;
        rd(4'h1, 8'h80);
        rd(4'h0, 8'h01);
        @(posedge mclk_in);
        por_bor_rst_in <= 1'b1;
        @(posedge mclk_in);
        por_bor_rst_in <= 1'b0;
        rd(4'h1, 8'h00);
        stop_test();
    end
endmodule : dipc_power_control_tb
`default_nettype wire
